// >>> verilog/port_six_pkg.sv
package port_six_pkg;
    // register map, one aligned word each
    localparam logic [7:0] PORT_REG_OFS   = 8'h00;
    localparam logic [7:0] SERIAL_CTL_OFS = 8'h04;
    // bit positions in the port location
    localparam int unsigned PIN2_BIT      = 2;
    localparam int unsigned PIN3_BIT      = 3;
    localparam int unsigned PULLUP_BIT    = 7;
    // bit positions in the serial control register
    localparam int unsigned SER_EN_BIT    = 7;
    localparam int unsigned SER_SYNC_BIT  = 4;
    localparam int unsigned SER_MAST_BIT  = 5;
    // reset values
    localparam logic [1:0] OD_LATCH_RST   = 2'h0;
    localparam logic       PULLUP_RST     = 1'b0;
    localparam logic [7:0] SER_CTL_RST    = 8'h00;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    // serial pin ownership modes
    typedef enum logic [1:0] {
        MODE_PORT,
        MODE_ASYNC,
        MODE_SYNC_SLAVE,
        MODE_SYNC_MASTER
    } serial_mode_e;
endpackage

// >>> verilog/pin_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser for a group of pin inputs
module pin_sync #(
    parameter int unsigned WIDTH = 6
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

// >>> verilog/port_six.sv
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/100ps
// What this block does
// - pin zero is input only and also feeds the first external interrupt input.
// - pin one is input only and also feeds the second interrupt and the timer clock input.
// - pins two and three are open-drain outputs driven from their latch bits.
// - with the serial port enabled, pin four is sync data both ways or async receive input.
// - with the serial port enabled, pin five is sync clock in or out, or async transmit out.
// - with the serial port disabled, pins four and five are plain input-only pins.
// - bit six of the port location always reads zero.
// - bit seven is a pinless control bit whose zero enables second-port weak pull-ups.
// - reads return pin levels while writes update the data latch.
// - writes change latch state only for pins two and three.
module port_six (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // classic wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // pins
    input  wire logic [5:0]  pin_i,
    output logic             pin_two_open_drain_oe_o,
    output logic             pin_three_open_drain_oe_o,
    output logic             pin_four_serial_rx_o,
    output logic             pin_four_serial_rx_oe_o,
    output logic             pin_five_serial_tx_o,
    output logic             pin_five_serial_tx_oe_o,
    // on-chip serial port side
    input  wire logic        sync_serial_data_out_i,
    input  wire logic        sync_serial_data_oe_i,
    input  wire logic        sync_serial_clock_out_i,
    input  wire logic        async_tx_data_i,
    output logic             serial_rx_data_o,
    output logic             sync_serial_clock_in_o,
    // interrupt, timer and second-port pull-up side
    output logic             ext_irq_a_o,
    output logic             timer_clock_irq_in_o,
    output logic             second_port_pullup_en_o
);
    import port_six_pkg::*;

    logic [5:0]   pins_s;
    logic [1:0]   od_latch_q;
    logic         pullup_ctl_q;
    logic [7:0]   ser_ctl_q;
    logic         ack_q;
    logic [31:0]  dat_q;
    logic         req;
    logic         wr_port;
    logic         wr_ser;
    logic [7:0]   port_view;
    serial_mode_e mode;

    // one address compare shared by the write strobes and the read checks below
    function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
        return adr == ofs;
    endfunction

    // pins arrive asynchronously, so every read sees them after two flops
    pin_sync #(.WIDTH(6)) u_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .async_i(pin_i),
        .sync_o (pins_s)
    );

    assign req     = cyc_i && stb_i && !ack_q;
    assign wr_port = req && we_i && sel_i[0] && reg_hit(adr_i, PORT_REG_OFS);
    assign wr_ser  = req && we_i && sel_i[0] && reg_hit(adr_i, SERIAL_CTL_OFS);

    // only pins two and three hold latched output state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            od_latch_q <= OD_LATCH_RST;
        end else if (wr_port) begin
            od_latch_q <= {dat_i[PIN3_BIT], dat_i[PIN2_BIT]};
        end
    end

    // pull-up control has no pin behind it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pullup_ctl_q <= PULLUP_RST;
        end else if (wr_port) begin
            pullup_ctl_q <= dat_i[PULLUP_BIT];
        end
    end

    // serial control stands in for the enable and mode bits of the uart
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ser_ctl_q <= SER_CTL_RST;
        end else if (wr_ser) begin
            ser_ctl_q <= dat_i[7:0];
        end
    end

    // decode who owns pins four and five
    always_comb begin
        if (!ser_ctl_q[SER_EN_BIT]) begin
            mode = MODE_PORT;
        end else if (!ser_ctl_q[SER_SYNC_BIT]) begin
            mode = MODE_ASYNC;
        end else if (ser_ctl_q[SER_MAST_BIT]) begin
            mode = MODE_SYNC_MASTER;
        end else begin
            mode = MODE_SYNC_SLAVE;
        end
    end

    // pin levels on 5:0, zero on 6, written control on 7
    assign port_view = {pullup_ctl_q, 1'b0, pins_s};

    // one wait state: answer the cycle after the request is seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= UNMAPPED_DATA;
        end else begin
            ack_q <= req;
            if (req && !we_i) begin
                case (adr_i)
                    PORT_REG_OFS:   dat_q <= {24'h00_0000, port_view};
                    SERIAL_CTL_OFS: dat_q <= {24'h00_0000, ser_ctl_q};
                    default:        dat_q <= UNMAPPED_DATA;
                endcase
            end
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;

    // open drain: drive low only while the latch holds zero
    assign pin_two_open_drain_oe_o   = !od_latch_q[0];
    assign pin_three_open_drain_oe_o = !od_latch_q[1];

    // pin four: sync data out when the uart drives it, else input
    always_comb begin
        pin_four_serial_rx_o    = 1'b0;
        pin_four_serial_rx_oe_o = 1'b0;
        case (mode)
            MODE_SYNC_SLAVE, MODE_SYNC_MASTER: begin
                pin_four_serial_rx_o    = sync_serial_data_out_i;
                pin_four_serial_rx_oe_o = sync_serial_data_oe_i;
            end
            default: begin
                pin_four_serial_rx_oe_o = 1'b0;
            end
        endcase
    end

    // pin five: tx out async, clock out as master, clock in as slave
    always_comb begin
        pin_five_serial_tx_o    = 1'b0;
        pin_five_serial_tx_oe_o = 1'b0;
        case (mode)
            MODE_ASYNC: begin
                pin_five_serial_tx_o    = async_tx_data_i;
                pin_five_serial_tx_oe_o = 1'b1;
            end
            MODE_SYNC_MASTER: begin
                pin_five_serial_tx_o    = sync_serial_clock_out_i;
                pin_five_serial_tx_oe_o = 1'b1;
            end
            default: begin
                pin_five_serial_tx_oe_o = 1'b0;
            end
        endcase
    end

    // inputs to the uart are gated so a disabled port feeds it idle levels
    assign serial_rx_data_o       = (mode != MODE_PORT) && pins_s[4];
    assign sync_serial_clock_in_o = (mode == MODE_SYNC_SLAVE) && pins_s[5];

    // interrupt and timer inputs always follow pins zero and one
    assign ext_irq_a_o             = pins_s[0];
    assign timer_clock_irq_in_o    = pins_s[1];
    assign second_port_pullup_en_o = !pullup_ctl_q;

    // assertions

    a_ack_one_wait: assert property (@(posedge clk_i) disable iff (rst_i)
        (cyc_i && stb_i && !ack_o) |=> ack_o)
        else $error("ack missing one cycle after request");

    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held more than one cycle");

    a_latch_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_port |=> (pin_two_open_drain_oe_o == !$past(dat_i[PIN2_BIT]))
                 && (pin_three_open_drain_oe_o == !$past(dat_i[PIN3_BIT])))
        else $error("open-drain latch did not follow write");

    a_latch_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_port |=> $stable(od_latch_q))
        else $error("latch changed without a port write");

    a_bit6_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (ack_o && $past(adr_i) == PORT_REG_OFS && !$past(we_i)) |-> !dat_o[6])
        else $error("bit six read non-zero");

    a_pullup_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (ack_o && $past(adr_i) == PORT_REG_OFS && !$past(we_i))
            |-> dat_o[7] == !second_port_pullup_en_o)
        else $error("bit seven read differs from pull-up control");

    a_pin_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (ack_o && $past(adr_i) == PORT_REG_OFS && !$past(we_i))
            |-> dat_o[5:0] == $past(pins_s))
        else $error("port read did not return pin levels");

    a_disabled_pins: assert property (@(posedge clk_i) disable iff (rst_i)
        !ser_ctl_q[SER_EN_BIT] |-> !pin_four_serial_rx_oe_o && !pin_five_serial_tx_oe_o)
        else $error("serial pin driven while port disabled");

    a_async_tx: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == MODE_ASYNC) |-> pin_five_serial_tx_oe_o && !pin_four_serial_rx_oe_o)
        else $error("async mode pin directions wrong");

    a_irq_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i, 2) |-> (ext_irq_a_o == $past(pin_i[0], 2)))
        else $error("interrupt input not two flops behind pin zero");

    a_timer_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i, 2) |-> (timer_clock_irq_in_o == $past(pin_i[1], 2)))
        else $error("timer clock not two flops behind pin one");

    // a read of each kind of location and a write with the low byte lane off, taken at one edge and answered at the next
    sequence s_port_read;
        req && !we_i && reg_hit(adr_i, PORT_REG_OFS);
    endsequence

    sequence s_ctl_read;
        req && !we_i && reg_hit(adr_i, SERIAL_CTL_OFS);
    endsequence

    sequence s_odd_read;
        req && !we_i && !reg_hit(adr_i, PORT_REG_OFS) && !reg_hit(adr_i, SERIAL_CTL_OFS);
    endsequence

    sequence s_refused_write;
        req && we_i && !sel_i[0];
    endsequence

    a_port_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        s_port_read |=> ack_o && dat_o[7:0] == {$past(pullup_ctl_q), 1'b0, $past(pins_s)})
        else $error("port read data wrong");

    a_ctl_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        s_ctl_read |=> ack_o && dat_o == {24'h00_0000, $past(ser_ctl_q)})
        else $error("serial control read data wrong");

    a_odd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        s_odd_read |=> ack_o && dat_o == UNMAPPED_DATA)
        else $error("unmapped read returned data");

    a_refused_write: assert property (@(posedge clk_i) disable iff (rst_i)
        s_refused_write |=> $stable(od_latch_q) && $stable(pullup_ctl_q) && $stable(ser_ctl_q))
        else $error("write without low byte lane changed state");

    a_ctl_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ser |=> ser_ctl_q == $past(dat_i[7:0]))
        else $error("serial control did not take write");

    a_pullup_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_port |=> second_port_pullup_en_o == !$past(dat_i[PULLUP_BIT]))
        else $error("pull-up enable did not follow write");

    a_pullup_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_port |=> $stable(pullup_ctl_q))
        else $error("pull-up control changed without a port write");

    a_sync_data: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == MODE_SYNC_SLAVE || mode == MODE_SYNC_MASTER)
            |-> pin_four_serial_rx_oe_o == sync_serial_data_oe_i
                && pin_four_serial_rx_o == sync_serial_data_out_i)
        else $error("sync data pin not driven by serial port");

    a_rx_route: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode != MODE_PORT) |-> serial_rx_data_o == pins_s[4])
        else $error("serial receive input not fed from pin four");

    a_master_clock: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == MODE_SYNC_MASTER)
            |-> pin_five_serial_tx_oe_o && pin_five_serial_tx_o == sync_serial_clock_out_i)
        else $error("master clock not driven on pin five");

    a_slave_clock: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == MODE_SYNC_SLAVE)
            |-> !pin_five_serial_tx_oe_o && sync_serial_clock_in_o == pins_s[5])
        else $error("slave clock not taken from pin five");

    a_async_data: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == MODE_ASYNC) |-> pin_five_serial_tx_o == async_tx_data_i)
        else $error("async transmit data not on pin five");

    a_port_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == MODE_PORT) |-> !serial_rx_data_o && !sync_serial_clock_in_o)
        else $error("serial inputs not idle while port disabled");
endmodule

// >>> test/pin_world.sv
`timescale 1ns/100ps
// outside world at the six pins: pull-ups on the open-drain pair
module pin_world (
    input  wire logic [5:0] ext_i,
    input  wire logic       two_oe_i,
    input  wire logic       three_oe_i,
    input  wire logic       four_i,
    input  wire logic       four_oe_i,
    input  wire logic       five_i,
    input  wire logic       five_oe_i,
    output logic      [5:0] pin_o
);
    // input-only pins just follow the outside level
    assign pin_o[1:0] = ext_i[1:0];
    // wired-and: either side sinking wins over the pull-up
    assign pin_o[2] = ext_i[2] & ~two_oe_i;
    assign pin_o[3] = ext_i[3] & ~three_oe_i;
    // serial pins: device drive wins while enabled, else outside level
    assign pin_o[4] = four_oe_i ? four_i : ext_i[4];
    assign pin_o[5] = five_oe_i ? five_i : ext_i[5];
endmodule

// >>> test/tb_six_bit_input_port_with_serial_mux.sv
`timescale 1ns/100ps
module tb_six_bit_input_port_with_serial_mux;
    import port_six_pkg::*;
    logic        clk_i, rst_i, cyc, stb, we, d_out, d_oe, c_out, tx;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, dat_o;
    logic [5:0]  ext, pins;
    logic        ack_o, oe2, oe3, p4, p4oe, p5, p5oe, rxd, ckin, irqa, tclk, puen;
    int          err_total, n_tests;
    logic [3:0]  own_seen;
    logic [1:0]  drv_seen;
    // mode table: control byte, {p4oe,p5oe,rxd,ckin}, {p4,p5} gated by oe
    localparam logic [31:0] CTL_TAB = 32'h0080_90b0;
    localparam logic [15:0] XO_TAB  = 16'h06be;
    localparam logic [7:0]  XV_TAB  = 8'h1a;

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    port_six i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .pin_i(pins),
        .pin_two_open_drain_oe_o(oe2), .pin_three_open_drain_oe_o(oe3),
        .pin_four_serial_rx_o(p4), .pin_four_serial_rx_oe_o(p4oe),
        .pin_five_serial_tx_o(p5), .pin_five_serial_tx_oe_o(p5oe),
        .sync_serial_data_out_i(d_out), .sync_serial_data_oe_i(d_oe),
        .sync_serial_clock_out_i(c_out), .async_tx_data_i(tx), .serial_rx_data_o(rxd),
        .sync_serial_clock_in_o(ckin), .ext_irq_a_o(irqa), .timer_clock_irq_in_o(tclk),
        .second_port_pullup_en_o(puen));

    pin_world i_world (.ext_i(ext), .two_oe_i(oe2), .three_oe_i(oe3), .four_i(p4),
        .four_oe_i(p4oe), .five_i(p5), .five_oe_i(p5oe), .pin_o(pins));

    // pin ownership and drive, gathered so each check fits one line
    assign own_seen = {p4oe, p5oe, rxd, ckin};
    assign drv_seen = {p4 & p4oe, p5 & p5oe};

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one classic cycle; waits on ack, only the watchdog ends a dead slave
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= s;
        wdat <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1);
        chk("ack_wait", 32'h0000_0002, n);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 4'hf);
        chk("read", {24'h00_0000, e}, rdat);
    endtask

    // pins pass two sync flops before they can be seen
    task automatic settle;
        repeat (4) @(posedge clk_i);
    endtask

    task automatic conclude;
        if (err_total == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // watchdog, far beyond the hundred or so cycles the tests need
    initial begin
        #(25 * 4000);
        err_total++;
        conclude();
    end

    initial begin
        {cyc, stb, we, d_out, d_oe, c_out, tx} = 7'h00;
        adr = 8'h00;
        sel = 4'hf;
        wdat = 32'h0000_0000;
        ext = 6'h3f;
        err_total = 0;
        n_tests = 0;
        rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        // after reset both latches sink, pull-ups enabled
        chk("pullup_en", 32'h1, {31'h0, puen});
        rd(PORT_REG_OFS, 8'h33);
        // whole-byte write releases both drivers; bits 0,1,4,5,6 not latched
        bus(1'b1, PORT_REG_OFS, 8'hcc, 4'hf);
        ext <= 6'h2a;
        settle();
        rd(PORT_REG_OFS, 8'haa);
        chk("pullup_en", 32'h0, {31'h0, puen});
        chk("irq_a", 32'h0, {31'h0, irqa});
        chk("timer_clk", 32'h1, {31'h0, tclk});
        chk("od_oe", 32'h0, {30'h0, oe3, oe2});
        // low byte lane off: write must be dropped
        bus(1'b1, PORT_REG_OFS, 8'h04, 4'he);
        chk("od_oe", 32'h0, {30'h0, oe3, oe2});
        bus(1'b1, PORT_REG_OFS, 8'h04, 4'hf);
        chk("od_oe", 32'h2, {30'h0, oe3, oe2});
        ext <= 6'h15;
        settle();
        rd(PORT_REG_OFS, 8'h15);
        chk("irq_a", 32'h1, {31'h0, irqa});
        chk("timer_clk", 32'h0, {31'h0, tclk});
        chk("pullup_en", 32'h1, {31'h0, puen});
        rd(8'h08, 8'h00);
        // serial ownership in every mode, serial side driving hard
        ext <= 6'h35;
        d_out <= 1'b1;
        d_oe <= 1'b1;
        tx <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, SERIAL_CTL_OFS, CTL_TAB[8*(3-i) +: 8], 4'hf);
            settle();
            chk("serial_own", {28'h0, XO_TAB[4*(3-i) +: 4]}, {28'h0, own_seen});
            chk("serial_drv", {30'h0, XV_TAB[2*(3-i) +: 2]}, {30'h0, drv_seen});
            rd(SERIAL_CTL_OFS, CTL_TAB[8*(3-i) +: 8]);
            if (i == 0) begin
                rd(PORT_REG_OFS, 8'h35);
            end
        end
        // mid-run reset puts latches, pull-up control and serial control back
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        chk("od_oe", 32'h3, {30'h0, oe3, oe2});
        chk("pullup_en", 32'h1, {31'h0, puen});
        chk("serial_own", 32'h0, {28'h0, own_seen});
        rd(SERIAL_CTL_OFS, 8'h00);
        rd(PORT_REG_OFS, 8'h31);
        conclude();
    end
endmodule
